// File: design/leadoff_regs_defines.vh
`ifndef LEADOFF_REGS_DEFINES_VH
`define LEADOFF_REGS_DEFINES_VH
`define ADDR_POS_STATUS 8'h12
`define ADDR_NEG_STATUS 8'h13
`define ADDR_IO_CTRL 8'h14
`define ADDR_MISC_ROUTING 8'h15
`define ADDR_MISC_RESERVED 8'h16
`define RST_STATUS 8'h00
`define RST_IO_DIR 4'hf
`define RST_IO_DATA 4'h0
`define RST_MISC 8'h00
`define RST_SYNC 4'h0
`define MISC_SRB_BIT 5
`define MISC_RSVD_MASK 8'h20
`define RESP_MODE_01 2'h1
`define RESP_MODE_11 2'h3
`define GP_SHARED_MASK 4'he
`define IO_ALL_PINS 4'hf
`define IO_DATA_HI 7
`define IO_DATA_LO 4
`define IO_DIR_HI 3
`define IO_DIR_LO 0
`define RST_OE 4'h0
`define RST_SWITCH 1'b0
`define RST_RDATA 8'h00
`define RSVD_READ 8'h00
`endif

// File: design/leadoff_status_gpio_misc_regs.v
// Operation
// - positive status bit per channel, 1 electrode off, 0 on
// - negative status bit per channel, 1 electrode off, 0 on
// - both status registers read-only, writes ignored, reset to zero
// - io data read returns actual level of the four pins
// - io data write drives output pins only; input pins unaffected
// - direction bit 0 makes pin output, 1 makes it input
// - io register at 14h, resets to 0fh, all pins inputs
// - respiration mode 01 or 11 takes io pins two to four away
// - misc bit 5 closes shared reference switches to inverting inputs
// - misc routing register at 15h resets to 00h, switches open
`include "leadoff_regs_defines.vh"
module leadoff_status_gpio_misc_regs (
  input wire clk_sys_i,
  input wire sys_rst_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  output reg [7:0] reg_rdata_o,
  input wire [7:0] pos_comp_off_i,
  input wire [7:0] neg_comp_off_i,
  input wire [1:0] respiration_control_i,
  input wire [3:0] io_pin_in_i,
  output reg [3:0] io_pin_out_o,
  output reg [3:0] io_pin_oe_o,
  output reg shared_reference_switch_o
);
  reg [7:0] pos_sync1_reg;
  reg [7:0] pos_sync2_reg;
  reg [7:0] pos_sync3_reg;
  reg [7:0] neg_sync1_reg;
  reg [7:0] neg_sync2_reg;
  reg [7:0] neg_sync3_reg;
  reg [3:0] pin_sync1_reg;
  reg [3:0] pin_sync2_reg;
  reg [3:0] pin_sync3_reg;
  reg [7:0] positive_electrode_status_reg;
  reg [7:0] positive_electrode_status_next;
  reg [7:0] negative_electrode_status_reg;
  reg [7:0] negative_electrode_status_next;
  reg [3:0] pin_level_reg;
  reg [3:0] pin_level_next;
  reg [3:0] io_pin_direction_reg;
  reg [3:0] io_pin_direction_next;
  reg [3:0] io_pin_data_reg;
  reg [3:0] io_pin_data_next;
  reg [7:0] misc_reference_routing_reg;
  reg [7:0] misc_reference_routing_next;
  reg [3:0] io_avail_mask;
  reg [3:0] io_pin_oe_next;
  reg [3:0] io_pin_out_next;
  reg shared_reference_switch_next;
  reg [7:0] rdata_next;
  wire io_ctrl_write;
  wire misc_routing_write;

  // true when a strobe addresses the given register
  function addr_match;
    input strobe;
    input [7:0] addr;
    input [7:0] target;
    begin
      addr_match = strobe && (addr == target);
    end
  endfunction

  // a bit moves only where the second and third stages agree
  function [7:0] settle_byte;
    input [7:0] held;
    input [7:0] stage2;
    input [7:0] stage3;
    begin
      settle_byte = (stage2 & stage3) | (held & (stage2 ^ stage3));
    end
  endfunction

  function [3:0] settle_nibble;
    input [3:0] held;
    input [3:0] stage2;
    input [3:0] stage3;
    begin
      settle_nibble = (stage2 & stage3) | (held & (stage2 ^ stage3));
    end
  endfunction

  // status and reserved addresses take no write
  assign io_ctrl_write = addr_match(reg_wr_i, reg_addr_i, `ADDR_IO_CTRL);
  assign misc_routing_write = addr_match(reg_wr_i, reg_addr_i, `ADDR_MISC_ROUTING);

  // pins 2..4 lost in respiration modes 01 and 11
  always @* begin
    io_avail_mask = `IO_ALL_PINS;
    if ((respiration_control_i == `RESP_MODE_01) || (respiration_control_i == `RESP_MODE_11)) begin
      io_avail_mask = ~`GP_SHARED_MASK;
    end
  end

  always @* begin
    positive_electrode_status_next = settle_byte(positive_electrode_status_reg,
      pos_sync2_reg, pos_sync3_reg);
    negative_electrode_status_next = settle_byte(negative_electrode_status_reg,
      neg_sync2_reg, neg_sync3_reg);
    pin_level_next = settle_nibble(pin_level_reg, pin_sync2_reg, pin_sync3_reg);
  end

  // a data bit is taken only for a pin that was already an output
  always @* begin
    io_pin_direction_next = io_pin_direction_reg;
    io_pin_data_next = io_pin_data_reg;
    if (io_ctrl_write) begin
      io_pin_direction_next = reg_wdata_i[`IO_DIR_HI:`IO_DIR_LO];
      io_pin_data_next = (reg_wdata_i[`IO_DATA_HI:`IO_DATA_LO] & ~io_pin_direction_reg) |
        (io_pin_data_reg & io_pin_direction_reg);
    end
  end

  // reserved bits are never stored
  always @* begin
    misc_reference_routing_next = misc_reference_routing_reg;
    if (misc_routing_write) begin
      misc_reference_routing_next = reg_wdata_i & `MISC_RSVD_MASK;
    end
  end

  always @* begin
    io_pin_oe_next = ~io_pin_direction_reg & io_avail_mask;
    io_pin_out_next = io_pin_data_reg & io_avail_mask;
    shared_reference_switch_next = misc_reference_routing_reg[`MISC_SRB_BIT];
  end

  // reserved and unmapped addresses read as zero
  always @* begin
    case (reg_addr_i)
      `ADDR_POS_STATUS: rdata_next = positive_electrode_status_reg;
      `ADDR_NEG_STATUS: rdata_next = negative_electrode_status_reg;
      `ADDR_IO_CTRL: rdata_next = {pin_level_reg, io_pin_direction_reg};
      `ADDR_MISC_ROUTING: rdata_next = misc_reference_routing_reg;
      `ADDR_MISC_RESERVED: rdata_next = `RSVD_READ;
      default: rdata_next = `RSVD_READ;
    endcase
  end

  // three stages on every input from outside the clock domain
  always @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pos_sync1_reg <= `RST_STATUS;
      pos_sync2_reg <= `RST_STATUS;
      pos_sync3_reg <= `RST_STATUS;
    end else begin
      pos_sync1_reg <= pos_comp_off_i;
      pos_sync2_reg <= pos_sync1_reg;
      pos_sync3_reg <= pos_sync2_reg;
    end
  end

  always @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      neg_sync1_reg <= `RST_STATUS;
      neg_sync2_reg <= `RST_STATUS;
      neg_sync3_reg <= `RST_STATUS;
    end else begin
      neg_sync1_reg <= neg_comp_off_i;
      neg_sync2_reg <= neg_sync1_reg;
      neg_sync3_reg <= neg_sync2_reg;
    end
  end

  always @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pin_sync1_reg <= `RST_SYNC;
      pin_sync2_reg <= `RST_SYNC;
      pin_sync3_reg <= `RST_SYNC;
    end else begin
      pin_sync1_reg <= io_pin_in_i;
      pin_sync2_reg <= pin_sync1_reg;
      pin_sync3_reg <= pin_sync2_reg;
    end
  end

  // status is read-only: only the comparators move it
  always @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      positive_electrode_status_reg <= `RST_STATUS;
      negative_electrode_status_reg <= `RST_STATUS;
      pin_level_reg <= `RST_SYNC;
    end else begin
      positive_electrode_status_reg <= positive_electrode_status_next;
      negative_electrode_status_reg <= negative_electrode_status_next;
      pin_level_reg <= pin_level_next;
    end
  end

  always @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      io_pin_direction_reg <= `RST_IO_DIR;
      io_pin_data_reg <= `RST_IO_DATA;
    end else begin
      io_pin_direction_reg <= io_pin_direction_next;
      io_pin_data_reg <= io_pin_data_next;
    end
  end

  always @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      misc_reference_routing_reg <= `RST_MISC;
    end else begin
      misc_reference_routing_reg <= misc_reference_routing_next;
    end
  end

  always @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      io_pin_oe_o <= `RST_OE;
      io_pin_out_o <= `RST_IO_DATA;
      shared_reference_switch_o <= `RST_SWITCH;
    end else begin
      io_pin_oe_o <= io_pin_oe_next;
      io_pin_out_o <= io_pin_out_next;
      shared_reference_switch_o <= shared_reference_switch_next;
    end
  end

  // read data holds until the next read
  always @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= `RST_RDATA;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rdata_next;
    end
  end
endmodule // leadoff_status_gpio_misc_regs

// File: test/io_pin_model.sv
module io_pin_model (input logic [3:0] io_pin_oe_o, io_pin_out_o, output logic [3:0] io_pin_in_i);
  timeunit 1ns; timeprecision 1ps;
  // undriven pins sit on board pulls in pattern a
  assign io_pin_in_i = (io_pin_oe_o & io_pin_out_o) | (~io_pin_oe_o & 4'ha);
endmodule // io_pin_model

// File: test/leadoff_status_gpio_misc_regs_test.sv
module leadoff_status_gpio_misc_regs_test;
  timeunit 1ns; timeprecision 1ps;
  logic clk_sys_i = 0, sys_rst_i = 1, reg_wr_i = 0, reg_rd_i = 0, shared_reference_switch_o;
  logic [7:0] reg_addr_i = 0, reg_wdata_i = 0, reg_rdata_o, pos_comp_off_i = 0, neg_comp_off_i = 0;
  logic [1:0] respiration_control_i = 0;
  logic [3:0] io_pin_in_i, io_pin_out_o, io_pin_oe_o;
  int fail_count = 0, checks = 0;
  always #2 clk_sys_i = ~clk_sys_i;
  leadoff_status_gpio_misc_regs leadoff_status_gpio_misc_regs_inst (.*);
  io_pin_model io_pin_model_inst (.*);
  task automatic chk(logic [7:0] seen, logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic acc(logic w, logic [7:0] a, logic [7:0] d);
    @(posedge clk_sys_i) #1;
    {reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} = {w, !w, a, d};
    @(posedge clk_sys_i) #1;
    {reg_wr_i, reg_rd_i} = 2'h0;
  endtask
  task automatic rdc(logic [7:0] a, logic [7:0] exp);
    acc(1'h0, a, 8'h00);
    chk(reg_rdata_o, exp);
  endtask
  task automatic t_status;
    {pos_comp_off_i, neg_comp_off_i} = 16'h813c;
    acc(1'h1, 8'h12, 8'hff);
    acc(1'h1, 8'h13, 8'h00);
    rdc(8'h12, 8'h81);
    rdc(8'h13, 8'h3c);
    $display("%m done");
  endtask
  task automatic t_io;
    acc(1'h1, 8'h14, 8'h50);
    acc(1'h1, 8'h14, 8'h5c);
    repeat (6) @(posedge clk_sys_i);
    rdc(8'h14, 8'h9c);
    chk({4'h0, io_pin_oe_o}, 8'h03);
    chk({4'h0, io_pin_out_o}, 8'h05);
    acc(1'h1, 8'h14, 8'h00);
    repeat (6) @(posedge clk_sys_i);
    rdc(8'h14, 8'h40);
    for (int m = 1; m < 5; m++) begin
      respiration_control_i = m[1:0];
      repeat (4) @(posedge clk_sys_i);
      #1 chk({4'h0, io_pin_oe_o}, m[0] ? 8'h01 : 8'h0f);
      chk({4'h0, io_pin_out_o}, m[0] ? 8'h00 : 8'h04);
    end
    $display("%m done");
  endtask
  task automatic t_misc;
    acc(1'h1, 8'h15, 8'h20);
    acc(1'h1, 8'h16, 8'h00);
    rdc(8'h15, 8'h20);
    chk({7'h0, shared_reference_switch_o}, 8'h01);
    acc(1'h1, 8'h15, 8'h00);
    rdc(8'h16, 8'h00);
    chk({7'h0, shared_reference_switch_o}, 8'h00);
    $display("%m done");
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk_sys_i);
    #1 sys_rst_i = 0;
    repeat (8) @(posedge clk_sys_i);
    rdc(8'h14, 8'haf);
    rdc(8'h15, 8'h00);
    t_status;
    t_io;
    t_misc;
    close_out;
  end
  initial begin
    #4000 fail_count++;
    close_out;
  end
endmodule // leadoff_status_gpio_misc_regs_test

// File: test/lgm_sva.sv
module lgm_sva (input logic clk_sys_i, sys_rst_i, reg_wr_i, reg_rd_i, shared_reference_switch_o,
  input logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, pos_comp_off_i, neg_comp_off_i,
  input logic [1:0] respiration_control_i, input logic [3:0] io_pin_in_i, io_pin_out_o, io_pin_oe_o);
  timeunit 1ns; timeprecision 1ps;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  a_reset_outputs: assert property ($fell(sys_rst_i) |-> !io_pin_oe_o && !shared_reference_switch_o)
    else $error("reset");
  a_switch_close: assert property (reg_wr_i && reg_addr_i == 8'h15 |->
    ##2 shared_reference_switch_o == $past(reg_wdata_i[5], 2)) else $error("switch");
  a_dir_select: assert property (reg_wr_i && reg_addr_i == 8'h14 |->
    ##2 io_pin_oe_o[0] == !$past(reg_wdata_i[0], 2)) else $error("dir");
  a_out_drive: assert property (reg_wr_i && reg_addr_i == 8'h14 && io_pin_oe_o[0] && !$past(reg_wr_i) |->
    ##2 io_pin_out_o[0] == $past(reg_wdata_i[4], 2)) else $error("drive");
  a_resp_disable: assert property (respiration_control_i[0] [*3] |-> io_pin_oe_o[3:1] == 3'h0)
    else $error("resp");
  a_pos_status: assert property ($stable(pos_comp_off_i) [*5] ##0 (reg_rd_i && reg_addr_i == 8'h12) |=>
    reg_rdata_o == $past(pos_comp_off_i)) else $error("pos");
  a_neg_status: assert property ($stable(neg_comp_off_i) [*5] ##0 (reg_rd_i && reg_addr_i == 8'h13) |=>
    reg_rdata_o == $past(neg_comp_off_i)) else $error("neg");
  a_io_level: assert property ($stable(io_pin_in_i) [*6] ##0 (reg_rd_i && reg_addr_i == 8'h14) |=>
    reg_rdata_o[7:4] == $past(io_pin_in_i)) else $error("io");
endmodule // lgm_sva
bind leadoff_status_gpio_misc_regs lgm_sva lgm_sva_inst (.*);
